// ### logic/tpw_cfg.svh
`ifndef TPW_CFG_SVH
`define TPW_CFG_SVH
// Register indices; byte address is four times the index
`define TPW_UNIT_STRIDE 16'h0030
`define TPW_IDX_MODE    16'h1fae
`define TPW_IDX_CLK     16'h1faf
`define TPW_IDX_OUT     16'h1fb2
`define TPW_IDX_CNT     16'h1fb4
`define TPW_IDX_PRD     16'h1fb6
`define TPW_IDX_CMPU    16'h1fb8
`define TPW_IDX_CMPV    16'h1fba
`define TPW_IDX_CMPW    16'h1fbc
`define TPW_IDX_DT      16'h1fbe
`define TPW_IDX_STS     16'h1fc0
`define TPW_IDX_MSK     16'h1fc1
// Mode control fields
`define TPW_MODE_HLF    7
`define TPW_MODE_DTY    6
`define TPW_MODE_POLU   5
`define TPW_MODE_POLL   4
`define TPW_MODE_DEC    3:2
`define TPW_MODE_SHAPE  1
`define TPW_MODE_EN     0
// Phase output control fields
`define TPW_OUT_DIR     15
`define TPW_OUT_EXP     14:12
`define TPW_OUT_PERIOD_SYNC_SEL   11
`define TPW_OUT_WAVE    10:8
`define TPW_OUT_SRC     7:6
// Status and mask bits
`define TPW_STS_PERIOD  0
`define TPW_STS_POSHIT  1
// Reset values
`define TPW_RST_MODE    8'h00
`define TPW_RST_CLK     2'h0
`define TPW_RST_OUT     16'h0000
`define TPW_RST_DT      6'h00
`define TPW_RST_PRD     12'h010
// Fc cycles per dead-time unit
`define TPW_DT_UNIT     9'h008
`endif

// ### logic/tpw_pkg.sv
package tpw_pkg;
	// APB request bundle from the master
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [15:0] paddr;
		logic [31:0] pwdata;
	} tpw_apb_req_t;

	// Upper and lower arm pins of the U, V, W phases
	typedef struct packed {
		logic [2:0] upper;
		logic [2:0] lower;
	} tpw_arms_t;

	typedef enum logic [1:0] {
		TPW_SYNC_NOW = 2'h0,
		TPW_SYNC_POS = 2'h1,
		TPW_SYNC_T1  = 2'h2,
		TPW_SYNC_T2  = 2'h3
	} tpw_sync_t;

	// Counter direction, one-hot
	typedef enum logic [1:0] {
		TPW_UP   = 2'b01,
		TPW_DOWN = 2'b10
	} tpw_dir_t;
endpackage : tpw_pkg

// ### logic/tpw_top.sv
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
`include "tpw_cfg.svh"

// Overview of operation
// RULE1: Two identical units at two register sets
// RULE2: Half-period irq when selected and decimation 00
// RULE3: Duty mode 0 shares U compare value
// RULE4: Polarity bits invert outputs when active low
// RULE5: Irq every 1, 2, 4, 8 periods
// RULE6: Shape bit picks sawtooth or triangle counting
// RULE7: Enable bit gates synthesis onto outputs
// RULE8: Software disables unit before changing settings
// RULE9: Dead time counts eight clocks per unit
// RULE10: Expected position bits compared after update
// RULE11: Sync source: now, position, timer1, timer2
// RULE12: Wave bits pick PWM or fixed level
// RULE13: Arm control field maps to arm levels
// RULE14: Period sync holds pending settings, rewritable
// RULE15: Period and compares double buffered per period
// RULE16: Direction flag reads 1 while counting down
// RULE17: Dead time between complementary arm edges
module tpw_top #(
	parameter int CW = 12
) (
	input  wire logic                  clock,
	input  wire logic                  rstn,
	input  wire tpw_pkg::tpw_apb_req_t apb_req,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [5:0]            pos_in,
	input  wire logic [1:0]            timer_evt,
	output tpw_pkg::tpw_arms_t         arms_q [2],
	output logic                       irq
);
	// Bus handshake: one wait state, commit on the pready edge
	logic        rdy_q;
	logic [31:0] rdata_q;
	logic        err_q;
	logic        irq_q;
	wire  [15:0] idx = {2'h0, apb_req.paddr[15:2]};
	wire         access = apb_req.psel & apb_req.penable;
	wire         wr_go = access & apb_req.pwrite & rdy_q;
	logic [31:0] rd_word [2];
	logic        unit_hit [2];
	logic        unit_irq [2];
	wire         any_hit = unit_hit[0] | unit_hit[1];
	wire  [31:0] rd_mux = unit_hit[0] ? rd_word[0] : rd_word[1];

	assign prdata = rdata_q;
	assign pready = rdy_q;
	assign pslverr = err_q;
	assign irq = irq_q;

	// Answer timing and read capture
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rdy_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			rdy_q <= access & ~rdy_q;
			rdata_q <= (access & ~rdy_q & ~apb_req.pwrite) ? rd_mux : 32'h0000_0000;
			err_q <= access & ~rdy_q & ~any_hit;
			irq_q <= unit_irq[0] | unit_irq[1];
		end
	end

	// Divider limit for a 2-bit power-of-two select
	function automatic logic [2:0] pow_lim(input logic [1:0] sel);
		pow_lim = 3'((4'h1 << sel) - 4'h1);
	endfunction : pow_lim

	genvar u;
	genvar p;
	generate
	for (u = 0; u < 2; u++) begin : g_unit
		// Register file of this unit
		logic [7:0]    mode_q;
		logic [1:0]    clk_q;
		logic [15:0]   out_q;
		logic [5:0]    dt_q;
		logic [CW-1:0] prd_buf_q;
		logic [CW-1:0] prd_q;
		logic [CW-1:0] cmp_buf_q [3];
		logic [CW-1:0] cmp_q [3];
		logic [1:0]    sts_q;
		logic [1:0]    msk_q;
		logic [CW-1:0] cnt_q;
		tpw_pkg::tpw_dir_t dir_q;
		logic [2:0]    pre_q;
		logic [2:0]    dec_q;
		logic [14:0]   act_q;
		logic          wait_q;
		logic [2:0]    ps1_q;
		logic [2:0]    ps2_q;
		logic [2:0]    ps3_q;

		// Address decode relative to this unit's base
		wire [15:0] loc = idx - 16'(u * `TPW_UNIT_STRIDE); // RULE1
		wire h_mode = loc == `TPW_IDX_MODE;
		wire h_clk  = loc == `TPW_IDX_CLK;
		wire h_out  = loc == `TPW_IDX_OUT;
		wire h_cnt  = loc == `TPW_IDX_CNT;
		wire h_prd  = loc == `TPW_IDX_PRD;
		wire h_cu   = loc == `TPW_IDX_CMPU;
		wire h_cv   = loc == `TPW_IDX_CMPV;
		wire h_cw   = loc == `TPW_IDX_CMPW;
		wire h_dt   = loc == `TPW_IDX_DT;
		wire h_sts  = loc == `TPW_IDX_STS;
		wire h_msk  = loc == `TPW_IDX_MSK;
		wire [31:0] wd = apb_req.pwdata;
		wire en    = mode_q[`TPW_MODE_EN];
		wire shape = mode_q[`TPW_MODE_SHAPE];
		wire is_dn = dir_q == tpw_pkg::TPW_DOWN;

		assign unit_hit[u] = h_mode | h_clk | h_out | h_cnt | h_prd | h_cu
			| h_cv | h_cw | h_dt | h_sts | h_msk;
		assign rd_word[u] =
			h_mode ? {24'h00_0000, mode_q} :
			h_clk  ? {30'h0000_0000, clk_q} :
			h_out  ? {16'h0000, is_dn, out_q[14:0]} : // RULE16
			h_cnt  ? 32'(cnt_q) :
			h_prd  ? 32'(prd_buf_q) :
			h_cu   ? 32'(cmp_buf_q[0]) :
			h_cv   ? 32'(cmp_buf_q[1]) :
			h_cw   ? 32'(cmp_buf_q[2]) :
			h_dt   ? {26'h000_0000, dt_q} :
			h_sts  ? {30'h0000_0000, sts_q} :
			h_msk  ? {30'h0000_0000, msk_q} : 32'h0000_0000;

		// Counter clock prescale and period events
		wire tick = en & (pre_q >= pow_lim(clk_q));
		wire at_top = cnt_q >= prd_q - CW'(1);
		wire wrap_e = tick & ~shape & at_top;               // RULE6
		wire top_c  = tick & shape & ~is_dn & at_top;
		wire bot_c  = tick & shape & is_dn & (cnt_q <= CW'(1));
		wire per_evt  = wrap_e | bot_c;
		wire half_evt = top_c | bot_c;
		wire load = ~en | per_evt;                          // RULE15
		wire dec_hit = per_evt & (dec_q == pow_lim(mode_q[`TPW_MODE_DEC]));
		wire hlf_sel = mode_q[`TPW_MODE_HLF] & (mode_q[`TPW_MODE_DEC] == 2'h0);
		wire prd_evt = hlf_sel ? half_evt : dec_hit;        // RULE2 RULE5

		// Output update synchronisation
		wire pos_chg = ps2_q != ps3_q;
		wire [1:0] src = out_q[`TPW_OUT_SRC];
		wire sync_hit = (src == 2'(tpw_pkg::TPW_SYNC_NOW)) |
			((src == 2'(tpw_pkg::TPW_SYNC_POS)) & pos_chg) |
			((src == 2'(tpw_pkg::TPW_SYNC_T1)) & timer_evt[0]) |
			((src == 2'(tpw_pkg::TPW_SYNC_T2)) & timer_evt[1]); // RULE11
		wire period_sync_sel = out_q[`TPW_OUT_PERIOD_SYNC_SEL];
		wire apply = period_sync_sel ? ((wait_q | sync_hit) & per_evt) : sync_hit;
		wire pos_ok = pos_chg & (ps2_q == act_q[`TPW_OUT_EXP]); // RULE10
		wire [1:0] ev = {pos_ok, prd_evt};
		wire sts_wr = wr_go & h_sts;

		// Register writes; software must disable before retuning
		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				mode_q <= `TPW_RST_MODE;
				clk_q <= `TPW_RST_CLK;
				out_q <= `TPW_RST_OUT;
				dt_q <= `TPW_RST_DT;
				prd_buf_q <= `TPW_RST_PRD;
				msk_q <= 2'h0;
			end else begin
				if (wr_go & h_mode) mode_q <= wd[7:0];
				if (wr_go & h_clk) clk_q <= wd[1:0];
				if (wr_go & h_out) out_q <= wd[15:0]; // RULE14
				if (wr_go & h_dt) dt_q <= wd[5:0];
				if (wr_go & h_prd) prd_buf_q <= wd[CW-1:0];
				if (wr_go & h_msk) msk_q <= wd[1:0];
			end
		end

		// Compare buffers, written and loaded per period
		for (p = 0; p < 3; p++) begin : g_cmp
			wire hc = (p == 0) ? h_cu : (p == 1) ? h_cv : h_cw;
			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					cmp_buf_q[p] <= '0;
					cmp_q[p] <= '0;
				end else begin
					if (wr_go & hc) cmp_buf_q[p] <= wd[CW-1:0];
					if (load) cmp_q[p] <= cmp_buf_q[p]; // RULE15
				end
			end
		end

		// Sticky status: an event beats a same-cycle clear
		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				sts_q <= 2'h0;
				unit_irq[u] <= 1'b0;
			end else begin
				sts_q <= (sts_q & ~(sts_wr ? wd[1:0] : 2'h0)) | ev;
				unit_irq[u] <= |(sts_q & msk_q);
			end
		end

		// PWM counter, sawtooth or triangle
		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				pre_q <= 3'h0;
				cnt_q <= '0;
				dir_q <= tpw_pkg::TPW_UP;
				prd_q <= `TPW_RST_PRD;
				dec_q <= 3'h0;
			end else begin
				pre_q <= (tick | ~en) ? 3'h0 : pre_q + 3'h1;
				if (load) prd_q <= prd_buf_q;
				if (!en) dec_q <= 3'h0;
				else if (per_evt) dec_q <= dec_hit ? 3'h0 : dec_q + 3'h1;
				if (!en) begin
					cnt_q <= '0;
					dir_q <= tpw_pkg::TPW_UP;
				end else if (tick) begin
					unique case (dir_q)
						tpw_pkg::TPW_UP: begin
							if (wrap_e) cnt_q <= '0;
							else if (top_c) begin
								cnt_q <= prd_q;
								dir_q <= tpw_pkg::TPW_DOWN; // RULE16
							end else cnt_q <= cnt_q + CW'(1);
						end
						tpw_pkg::TPW_DOWN: begin
							if (bot_c) begin
								cnt_q <= '0;
								dir_q <= tpw_pkg::TPW_UP;
							end else cnt_q <= cnt_q - CW'(1);
						end
					endcase
				end
			end
		end

		// Position pins synchroniser and pending update
		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				ps1_q <= 3'h0;
				ps2_q <= 3'h0;
				ps3_q <= 3'h0;
				act_q <= 15'h0000;
				wait_q <= 1'b0;
			end else begin
				ps1_q <= pos_in[3*u +: 3];
				ps2_q <= ps1_q;
				ps3_q <= ps2_q;
				if (apply) act_q <= out_q[14:0];
				wait_q <= period_sync_sel & ~apply & (wait_q | sync_hit); // RULE14
			end
		end

		// Duty compare per phase
		wire [CW-1:0] cmp_u = cmp_q[0];
		for (p = 0; p < 3; p++) begin : g_ph
			logic [8:0] dtc_q;
			logic       prev_q;
			wire [CW-1:0] duty = mode_q[`TPW_MODE_DTY] ? cmp_q[p] : cmp_u; // RULE3
			wire pwm = cnt_q < duty;
			wire wave = act_q[8+p];
			wire [1:0] oc = act_q[2*p +: 2];
			wire both = wave & (oc[1] == oc[0]);
			wire [8:0] dtc_d = (pwm != prev_q) ? 9'(dt_q) * `TPW_DT_UNIT // RULE9
				: (dtc_q != 9'h000) ? dtc_q - 9'h001 : 9'h000;
			wire blank = both & (dtc_d != 9'h000);               // RULE17
			wire up_v = (wave ? (oc != 2'b01) & pwm : oc[1]) & ~blank; // RULE12 RULE13
			wire lo_v = (wave ? (oc != 2'b10) & ~pwm : oc[0]) & ~blank;
			wire pu = mode_q[`TPW_MODE_POLU];
			wire pl = mode_q[`TPW_MODE_POLL];
			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					dtc_q <= 9'h000;
					prev_q <= 1'b0;
					arms_q[u].upper[p] <= 1'b1;
					arms_q[u].lower[p] <= 1'b1;
				end else begin
					dtc_q <= dtc_d;
					prev_q <= pwm;
					arms_q[u].upper[p] <= en ? ~(up_v ^ pu) : ~pu; // RULE4 RULE7
					arms_q[u].lower[p] <= en ? ~(lo_v ^ pl) : ~pl;
				end
			end
		end
	end
	endgenerate
endmodule : tpw_top

// ### sim/tpw_gate_model.sv
`timescale 1ns/1ns

module tpw_gate_model #(
	parameter int STEP = 40
) (
	input wire logic   clock,
	input wire logic   rstn,
	output logic [5:0] hall
);
	localparam logic [2:0] SEQ [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
	int unsigned tick_q;
	int unsigned ph_q;

	// Rotor sensors step through six positions while the motor turns
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tick_q <= 0;
			ph_q   <= 0;
		end else if (tick_q == STEP - 1) begin
			tick_q <= 0;
			ph_q   <= (ph_q + 1) % 6;
		end else begin
			tick_q <= tick_q + 1;
		end
	end
	// Second motor runs half a turn apart
	assign hall = {SEQ[(ph_q + 3) % 6], SEQ[ph_q]};
endmodule : tpw_gate_model

// ### sim/tpw_top_asserts.sv
`timescale 1ns/1ns
`include "tpw_cfg.svh"

module tpw_top_asserts #(
	parameter int CW = 12
) (
	input wire logic                  clock,
	input wire logic                  rstn,
	input wire tpw_pkg::tpw_apb_req_t apb_req,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic [5:0]            pos_in,
	input wire logic [1:0]            timer_evt,
	input wire tpw_pkg::tpw_arms_t    arms_q [2],
	input wire logic                  irq
);
	localparam logic [15:0] A_MODE = `TPW_IDX_MODE << 2;
	localparam logic [15:0] A_OUT = `TPW_IDX_OUT << 2;
	localparam logic [15:0] A_MSK = `TPW_IDX_MSK << 2;
	localparam logic [15:0] A_MSK1 = (`TPW_IDX_MSK + `TPW_UNIT_STRIDE) << 2;
	logic [7:0]  mode_q;
	logic [14:0] out_q;
	logic [1:0]  msk_q;
	// Committed write and active arm levels of unit 0
	wire         wr_hit = apb_req.psel & apb_req.penable & pready & apb_req.pwrite;
	wire [2:0]   act_u = arms_q[0].upper ~^ {3{mode_q[5]}};
	wire [2:0]   act_l = arms_q[0].lower ~^ {3{mode_q[4]}};

	// Shadow copies of settings written by software
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mode_q <= 8'h00;
			out_q  <= 15'h0000;
			msk_q  <= 2'h0;
		end else if (wr_hit) begin
			if (apb_req.paddr == A_MODE) mode_q <= apb_req.pwdata[7:0];
			if (apb_req.paddr == A_OUT) out_q <= apb_req.pwdata[14:0];
			if (apb_req.paddr == A_MSK) msk_q[0] <= |apb_req.pwdata[1:0];
			if (apb_req.paddr == A_MSK1) msk_q[1] <= |apb_req.pwdata[1:0];
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_wait: assert property (apb_req.psel && !apb_req.penable
		|=> !pready ##1 pready) else $error("pready not in second access");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside reply");
	a_idle_level: assert property (
		(!mode_q[0] && $stable(mode_q))[*3] |-> arms_q[0].upper ==
		{3{~mode_q[5]}} && arms_q[0].lower == {3{~mode_q[4]}})
		else $error("disabled arms not inactive");
	a_level_map: assert property (
		(mode_q[0] && out_q[11:6] == 6'h00 && $stable(out_q)
		&& $stable(mode_q))[*3] |-> arms_q[0].upper[0] == (out_q[1] ~^
		mode_q[5]) && arms_q[0].lower[0] == (out_q[0] ~^ mode_q[4]))
		else $error("fixed level wrong");
	a_no_overlap: assert property (
		(mode_q[0] && out_q[11:0] == 12'h700 && $stable(out_q))[*3]
		|-> (act_u & act_l) == 3'h0) else $error("both arms active");
	a_irq_masked: assert property (irq |-> ($past(msk_q) | $past(msk_q, 2))
		!= 2'h0) else $error("irq with all sources masked");
	a_dir_edge: assert property (
		pready && !apb_req.pwrite && apb_req.paddr == A_OUT && !mode_q[1]
		|-> !prdata[15]) else $error("down flag in edge mode");

	c_irq: cover property ($rose(irq));
	c_err: cover property (pslverr);
	c_pwm: cover property (mode_q[0] && out_q[11:0] == 12'h700);
endmodule : tpw_top_asserts

bind tpw_top tpw_top_asserts #(.CW(CW)) u_chk (
	.clock(clock), .rstn(rstn), .apb_req(apb_req), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .pos_in(pos_in),
	.timer_evt(timer_evt), .arms_q(arms_q), .irq(irq));

// ### sim/tpw_top_bench.sv
`timescale 1ns/1ns
`include "tpw_cfg.svh"

module tpw_top_bench;
	logic                  clock = 1'b0;
	logic                  rstn = 1'b0;
	tpw_pkg::tpw_apb_req_t req = '0;
	logic [31:0]           prdata;
	logic                  pready;
	logic                  pslverr;
	logic [5:0]            pos_in;
	logic [1:0]            timer_evt = 2'h0;
	tpw_pkg::tpw_arms_t    arms_q [2];
	logic                  irq;
	logic [31:0]           rd_d;
	logic                  rd_e;
	logic [7:0]            mv;
	int                    k;
	int unsigned           t0;
	int                    err_count = 0;
	int                    checks_done = 0;
	int unsigned           cyc = 0;
	int unsigned           mdl [int];
	int unsigned           wm [int];
	int                    ix [4] = '{`TPW_IDX_MODE, `TPW_IDX_CLK,
		`TPW_IDX_DT, `TPW_IDX_OUT};
	int unsigned           wv [4] = '{32'h0000_00ff, 32'h0000_0003,
		32'h0000_003f, 32'h0000_7fff};
	logic [7:0]            md [6] = '{8'h01, 8'h05, 8'h09, 8'h0d, 8'h03, 8'h83};
	int unsigned           ep [6] = '{16, 32, 64, 128, 32, 16};

	always #2 clock = ~clock;
	// Cycle count and sparse timer pulses
	always @(posedge clock) cyc <= cyc + 1;
	always @(posedge clock) timer_evt <= {cyc % 53 == 0, cyc % 37 == 0};

	tpw_top dut (
		.clock(clock), .rstn(rstn), .apb_req(req), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pos_in(pos_in),
		.timer_evt(timer_evt), .arms_q(arms_q), .irq(irq));
	tpw_gate_model u_gate (.clock(clock), .rstn(rstn), .hall(pos_in));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk

	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input int i, input logic [31:0] d);
		@(posedge clock);
		req <= '{1'b1, 1'b0, w, 16'(i << 2), d};
		@(posedge clock);
		req.penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd_d = prdata;
		rd_e = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	task automatic wr(input int i, input logic [31:0] d);
		apb(1'b1, i, d);
		if (mdl.exists(i)) mdl[i] = d & wm[i];
	endtask : wr

	task automatic rdc(input int i);
		apb(1'b0, i, 32'h0000_0000);
		chk(rd_d, mdl[i]);
	endtask : rdc

	// Waits for a fresh rise of the interrupt line
	task automatic wait_irq;
		int n;
		n = 0;
		while (irq === 1'b1 && n < 300) begin
			@(posedge clock);
			n++;
		end
		while (irq !== 1'b1 && n < 600) begin
			@(posedge clock);
			n++;
		end
	endtask : wait_irq

	task automatic wrap_up;
		if (err_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : wrap_up

	initial begin
		repeat (20000) @(posedge clock);
		err_count++;
		wrap_up;
	end

	// Reset values, random access, fixed levels, interrupt spacing
	initial begin
		void'($urandom(32'hbdfd));
		for (int j = 0; j < 8; j++) begin
			mdl[ix[j % 4] + j / 4 * `TPW_UNIT_STRIDE] = 0;
			wm[ix[j % 4] + j / 4 * `TPW_UNIT_STRIDE] = wv[j % 4];
		end
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		foreach (mdl[i]) rdc(i);
		apb(1'b0, 32'h0000_1fa0, 32'h0000_0000);
		chk(rd_e, 1'b1);
		for (int n = 0; n < 24; n++) begin
			k = ix[$urandom % 3] + n % 2 * `TPW_UNIT_STRIDE;
			wr(k, $urandom & 32'hffff_fffe);
			foreach (mdl[i]) rdc(i);
		end
		for (k = 0; k < 8; k++) begin
			mv = {2'h0, {2{k[2]}}, 4'h0};
			wr(`TPW_IDX_MODE, mv);
			wr(`TPW_IDX_OUT, k[1:0]);
			wr(`TPW_IDX_MODE, mv | 8'h01);
			repeat (4) @(posedge clock);
			chk(arms_q[0].upper[0], k[2] ? k[1] : !k[1]);
			chk(arms_q[0].lower[0], k[2] ? k[0] : !k[0]);
			wr(`TPW_IDX_MODE, mv);
			repeat (4) @(posedge clock);
			chk(arms_q[0].upper, {3{!k[2]}});
		end
		// Second unit stays disabled at its modelled polarity
		mv = 8'(mdl[`TPW_IDX_MODE + `TPW_UNIT_STRIDE]);
		chk(arms_q[1].upper, {3{~mv[5]}});
		chk(arms_q[1].lower, {3{~mv[4]}});
		wr(`TPW_IDX_DT, 32'h0000_0001);
		wr(`TPW_IDX_CLK, 32'h0000_0000);
		wr(`TPW_IDX_CMPU, 32'h0000_0008);
		wr(`TPW_IDX_OUT, 32'h0000_0700);
		wr(`TPW_IDX_MSK, 32'h0000_0001);
		for (k = 0; k < 6; k++) begin
			wr(`TPW_IDX_MODE, 32'h0000_0000);
			wr(`TPW_IDX_MODE, md[k]);
			wr(`TPW_IDX_STS, 32'h0000_0001);
			wait_irq;
			t0 = cyc;
			wr(`TPW_IDX_STS, 32'h0000_0001);
			wait_irq;
			chk(cyc - t0, ep[k]);
		end
		wr(`TPW_IDX_MSK, 32'h0000_0000);
		repeat (40) @(posedge clock);
		chk(irq, 1'b0);
		wrap_up;
	end
endmodule : tpw_top_bench
